// ==== hdl/mcr_consts.svh ====
// Offsets, field positions, codes and timing figures of the control framer
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH
// Register byte offsets
`define CTRL_OFS 8'h00
`define TXHDR_OFS 8'h04
`define TXCAP_OFS 8'h08
`define TXHWLO_OFS 8'h0c
`define TXHWHI_OFS 8'h10
`define STAT_OFS 8'h14
`define RXHDR_OFS 8'h18
`define RXCAP_OFS 8'h1c
`define RXHWLO_OFS 8'h20
`define RXHWHI_OFS 8'h24
`define KEY_TOP 3'b010
// Command and role bits in the control word
`define CMD_START 0
`define CMD_REPLY 1
`define CMD_THIRD 2
`define CMD_ACK 3
`define CFG_BASE 4
`define CMD_WANT_RSP 5
// Control type codes
`define KIND_ENROL 4'h1
`define KIND_LINK 4'h2
`define KIND_ELEV 4'h3
`define KIND_SLOT 4'h4
`define KIND_LAYOUT 4'h5
`define KIND_CFREQ 4'h6
`define KIND_KALIVE 4'h7
`define KIND_GROUP 4'h8
`define KIND_PHYROB 4'h9
`define KIND_CIPHER 4'ha
// Enrolment field positions: aggregation bit within the caps field, negative bit within the payload
`define CAP_PA_BIT 5
`define ENR_NEG_BIT 319
// Timing
`define PCLK_NS 8
`define RETRY_TIMEOUT_NS 100000
`define RETRY_LIMIT 3
`endif

// ==== hdl/mcr_pkg.sv ====
// Types shared by the control framer modules
package mcr_pkg;
	// Control packet header as seen on the packet ports
	typedef struct packed {
		logic ctl_flag;
		logic is_reply;
		logic uplink;
		logic [3:0] kind;
		logic [7:0] switch_ident_field;
		logic [13:0] local_node_ident_field;
	} pkt_hdr_t;
	// Enrolment payload, most significant field first
	typedef struct packed {
		logic neg;
		logic roam;
		logic [1:0] security_capability_field;
		logic [1:0] rsvd;
		logic [6:0] caps;
		logic [2:0] ktime;
		logic [47:0] node_hw_address;
		logic [127:0] encrypted_network_key;
		logic [127:0] encrypted_auth_key;
	} enrol_t;
	// Header plus payload of one outgoing packet
	typedef struct packed {
		pkt_hdr_t hdr;
		logic [319:0] payload;
	} pkt_t;
	// Retransmit engine state
	typedef enum logic [0:0] {
		ENG_IDLE = 1'b0,
		ENG_WAIT = 1'b1
	} eng_state_t;
endpackage

// ==== hdl/retx_engine.sv ====
// Retransmit timer and counter for one control transaction
`timescale 1ns/1ps
module retx_engine #(
	parameter int unsigned TIMEOUT_CYC = 12500,
	parameter int unsigned LIMIT = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic stop,
	output logic resend,
	output logic fail,
	output logic busy,
	output logic [$clog2(LIMIT+1)-1:0] cnt
);
	import mcr_pkg::*;
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [TW-1:0] RELOAD = TW'(TIMEOUT_CYC - 1);
	localparam logic [CW-1:0] LIM = CW'(LIMIT);
	generate if (TIMEOUT_CYC < 1 || LIMIT < 1) begin : g_bad
		$error("retx_engine: timeout and limit must be at least one");
	end endgenerate

	eng_state_t state, next_state; // Waiting for an answer or idle
	logic [TW-1:0] timer, next_timer; // Cycles left before expiry
	logic [CW-1:0] next_cnt;
	logic next_resend, next_fail;

	////////////////////////////////////////////////////////////////////
	// Timer and counter next state
	always_comb begin
		next_state = state;
		next_timer = timer;
		next_cnt = cnt;
		next_resend = 1'b0;
		next_fail = 1'b0;
		unique case (state)
			ENG_IDLE: begin
				next_state = ENG_IDLE;
			end
			ENG_WAIT: begin
				// RULE7: answer stops timer
				if (stop) begin
					next_state = ENG_IDLE;
				end else if (timer == '0) begin
					// RULE9: expiry bumps count, resend
					next_cnt = cnt + 1'b1;
					if (next_cnt < LIM) begin
						next_resend = 1'b1;
						next_timer = RELOAD;
					end else begin
						// RULE10: limit reached, give up
						next_fail = 1'b1;
						next_state = ENG_IDLE;
					end
				end else begin
					next_timer = timer - 1'b1;
				end
			end
		endcase
		// RULE6: first message loads timer, clears count
		if (start) begin
			next_state = ENG_WAIT;
			next_timer = RELOAD;
			next_cnt = '0;
		end
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ENG_IDLE;
			timer <= '0;
			cnt <= '0;
			resend <= 1'b0;
			fail <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			cnt <= next_cnt;
			resend <= next_resend;
			fail <= next_fail;
		end
	end
	assign busy = (state == ENG_WAIT);

	////////////////////////////////////////////////////////////////////
	// Checks
	start_clears_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		start |=> busy && cnt == '0 && timer == RELOAD)
		else $error("start did not load timer and clear count");
	resend_below_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		resend |-> cnt != '0 && cnt < LIM && busy)
		else $error("resend outside the retry range");
	fail_at_limit_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		fail |-> cnt == LIM && !busy)
		else $error("failure reported away from the limit");
	stop_idles_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		busy && stop && !start |=> !busy && !resend && !fail)
		else $error("answer did not stop the timer");
endmodule

// ==== hdl/enrol_codec.sv ====
// Enrolment payload packing and parsing
`timescale 1ns/1ps
`include "mcr_consts.svh"
module enrol_codec (
	input wire mcr_pkg::enrol_t src,
	input wire mcr_pkg::pkt_hdr_t hdr,
	input wire logic role_base,
	input wire logic [7:0] path_agg,
	input wire logic [319:0] rx_payload,
	output wire mcr_pkg::enrol_t rx_fields,
	output wire logic [319:0] tx_payload
);
	import mcr_pkg::*;
	enrol_t fix; // Outgoing fields after adjustment

	////////////////////////////////////////////////////////////////////
	// Adjust outgoing enrolment fields; other kinds pass raw
	always_comb begin
		fix = src;
		if (hdr.kind == `KIND_ENROL) begin
			fix.rsvd = '0;
			// RULE21: keepalive time only in response
			if (!(hdr.is_reply && !hdr.uplink)) begin
				fix.ktime = '0;
			end
			// RULE19: base reports path-wide aggregation
			if (!hdr.uplink && role_base) begin
				fix.caps[`CAP_PA_BIT] = &path_agg;
			end
		end
	end

	// RULE23: fields packed most significant first
	assign tx_payload = fix;
	// RULE15: receive side reads the same layout
	assign rx_fields = rx_payload;
endmodule

// ==== hdl/mac_control_retransmit.sv ====
// Control-message framer with requester and responder retransmission
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// RULE1: Control packets carry the control flag set
// RULE2: Type field selects one of ten kinds
// RULE3: Payload layout decoded by type field
// RULE4: Retransmit listed kinds when response needed
// RULE5: Keep retransmit counter and timer per transaction
// RULE6: First send loads timer, clears counter
// RULE7: Response stops timer, completes transaction
// RULE8: Late responses are silently tolerated
// RULE9: Expiry increments counter, resends below limit
// RULE10: At limit stop and report failure
// RULE11: Failed service node becomes disconnected
// RULE12: Duplicate request only resends the reply
// RULE13: New request is processed and answered
// RULE14: Responder retries in three-message transactions
// RULE15: Enrolment meaning depends on direction
// RULE16: Switch identifier names registering switch
// RULE17: Local identifier carries assigned node identifier
// RULE18: Terminal reports own aggregation ability uplink
// RULE19: Base sets aggregation only if path capable
// RULE20: Enrolment field widths as defined layout
// RULE21: Keepalive time zero except enrolment response
// RULE22: Negative and roaming bits meaning fixed
// RULE23: Enrolment fields packed most significant first
// RULE24: Duplicates found by kind, sender, content
// RULE25: Timeout and limit are constant parameters
`include "mcr_consts.svh"
module mac_control_retransmit #(
	parameter int unsigned RETRY_TIMEOUT_CYC =
		(`RETRY_TIMEOUT_NS + `PCLK_NS - 1) / `PCLK_NS,
	parameter int unsigned RETRY_LIMIT = `RETRY_LIMIT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire mcr_pkg::pkt_hdr_t rx_hdr,
	input wire logic [319:0] rx_payload,
	input wire logic tx_ready,
	output logic tx_valid,
	output mcr_pkg::pkt_hdr_t tx_hdr,
	output logic [319:0] tx_payload,
	output logic link_up
);
	import mcr_pkg::*;
	localparam int CW = $clog2(RETRY_LIMIT + 1);
	// RULE25: counter must reach limit within status field
	generate if (RETRY_LIMIT < 1 || RETRY_LIMIT > 15) begin : g_bad
		$error("mac_control_retransmit: retry limit must be 1 to 15");
	end endgenerate

	////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic role_base, next_role_base; // Device acts as base node
	pkt_hdr_t cfg_hdr, next_cfg_hdr; // Header of next outgoing packet
	logic [15:0] cfg_cap, next_cfg_cap; // Enrolment flag half-word
	logic [7:0] path_agg, next_path_agg; // Aggregation per hop on path
	logic [47:0] cfg_hw, next_cfg_hw; // Own hardware address
	logic [31:0] key_word [8]; // Two keys, four words each
	logic [31:0] next_key_word [8];
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	// Transaction state
	pkt_t req_pkt, next_req_pkt; // Request kept for resends
	pkt_t rep_pkt, next_rep_pkt; // Last reply kept for duplicates
	logic pend_req, next_pend_req;
	logic pend_rep, next_pend_rep;
	logic have_rep, next_have_rep;
	logic req_done, next_req_done;
	logic req_fail, next_req_fail;
	logic rsp_fail, next_rsp_fail;
	logic new_msg, next_new_msg; // Unacknowledged new request waiting
	pkt_hdr_t last_hdr, next_last_hdr; // Last request taken
	logic [319:0] last_pl, next_last_pl;
	logic have_last, next_have_last;
	logic next_tx_valid, next_link_up;
	pkt_hdr_t next_tx_hdr;
	logic [319:0] next_tx_payload;
	// Decodes and engine signals
	logic wr_en, rd_en, key_hit, mapped;
	logic start_cmd, reply_cmd, third_cmd, ack_cmd, want_rsp;
	logic needs_retx, rx_ctl, rsp_hit, rx_req, dup, third_hit;
	logic req_resend, req_fail_p, req_busy;
	logic rsp_resend, rsp_fail_p, rsp_busy;
	logic [CW-1:0] req_cnt, rsp_cnt;
	enrol_t tx_fields, rx_fields;
	logic [319:0] tx_pl;
	pkt_hdr_t out_hdr;

	////////////////////////////////////////////////////////////////////
	// APB decode; access completes on the cycle after setup
	assign wr_en = psel && penable && pready && pwrite;
	assign rd_en = psel && !penable;
	assign key_hit = (paddr[7:5] == `KEY_TOP) && (paddr[1:0] == 2'b00);
	assign start_cmd = wr_en && paddr == `CTRL_OFS && pwdata[`CMD_START];
	assign reply_cmd = wr_en && paddr == `CTRL_OFS && pwdata[`CMD_REPLY];
	assign third_cmd = pwdata[`CMD_THIRD];
	assign ack_cmd = wr_en && paddr == `CTRL_OFS && pwdata[`CMD_ACK];
	assign want_rsp = pwdata[`CMD_WANT_RSP];

	// Address map check
	always_comb begin
		unique case (paddr)
			`CTRL_OFS, `TXHDR_OFS, `TXCAP_OFS, `TXHWLO_OFS, `TXHWHI_OFS,
			`STAT_OFS, `RXHDR_OFS, `RXCAP_OFS, `RXHWLO_OFS,
			`RXHWHI_OFS: mapped = 1'b1;
			default: mapped = key_hit;
		endcase
	end

	// Configuration next values and read data
	always_comb begin
		next_role_base = role_base;
		next_cfg_hdr = cfg_hdr;
		next_cfg_cap = cfg_cap;
		next_path_agg = path_agg;
		next_cfg_hw = cfg_hw;
		next_key_word = key_word;
		next_pready = psel && !penable;
		next_pslverr = psel && !penable && !mapped;
		next_prdata = prdata;
		if (wr_en) begin
			unique case (paddr)
				`CTRL_OFS: next_role_base = pwdata[`CFG_BASE];
				// RULE16: switch and RULE17 node identifiers set here
				`TXHDR_OFS: next_cfg_hdr = pwdata[$bits(pkt_hdr_t)-1:0];
				`TXCAP_OFS: begin
					next_cfg_cap = pwdata[15:0];
					next_path_agg = pwdata[23:16];
				end
				`TXHWLO_OFS: next_cfg_hw[31:0] = pwdata;
				`TXHWHI_OFS: next_cfg_hw[47:32] = pwdata[15:0];
				default: begin
					if (key_hit) begin
						next_key_word[paddr[4:2]] = pwdata;
					end
				end
			endcase
		end
		if (rd_en) begin
			unique case (paddr)
				`CTRL_OFS: next_prdata = {27'h0, role_base, 4'h0};
				`TXHDR_OFS: next_prdata = 32'(cfg_hdr);
				`TXCAP_OFS: next_prdata = {8'h0, path_agg, cfg_cap};
				`TXHWLO_OFS: next_prdata = cfg_hw[31:0];
				`TXHWHI_OFS: next_prdata = {16'h0, cfg_hw[47:32]};
				`STAT_OFS: next_prdata = {16'h0, 4'(rsp_cnt), 4'(req_cnt),
					link_up, new_msg, rsp_fail, rsp_busy,
					req_fail, req_done, req_busy, have_rep};
				`RXHDR_OFS: next_prdata = 32'(last_hdr);
				// RULE22: negative and roaming bits read back as sent
				`RXCAP_OFS: next_prdata = {16'h0, last_pl[319:304]};
				`RXHWLO_OFS: next_prdata = rx_fields.node_hw_address[31:0];
				`RXHWHI_OFS: next_prdata = {16'h0, rx_fields.node_hw_address[47:32]};
				default: next_prdata = key_hit ? key_word[paddr[4:2]] : 32'h0;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			role_base <= 1'b0;
			cfg_hdr <= '0;
			cfg_cap <= 16'h0;
			path_agg <= 8'h0;
			cfg_hw <= 48'h0;
			for (int i = 0; i < 8; i++) begin
				key_word[i] <= 32'h0;
			end
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			role_base <= next_role_base;
			cfg_hdr <= next_cfg_hdr;
			cfg_cap <= next_cfg_cap;
			path_agg <= next_path_agg;
			cfg_hw <= next_cfg_hw;
			key_word <= next_key_word;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Payload assembly
	// RULE20: enrolment field widths
	assign tx_fields = {cfg_cap, cfg_hw, key_word[0], key_word[1], key_word[2],
		key_word[3], key_word[4], key_word[5], key_word[6], key_word[7]};
	// RULE18: uplink keeps own aggregation bit from software
	enrol_codec u_codec (
		.src(tx_fields),
		.hdr(out_hdr),
		.role_base(role_base),
		.path_agg(path_agg),
		.rx_payload(last_pl),
		.rx_fields(rx_fields),
		.tx_payload(tx_pl)
	);

	// RULE1: outgoing header always flagged as control
	always_comb begin
		out_hdr = cfg_hdr;
		out_hdr.ctl_flag = 1'b1;
		out_hdr.is_reply = reply_cmd;
	end

	// RULE4: only these kinds run the request retransmit engine
	always_comb begin
		unique case (cfg_hdr.kind)
			`KIND_ENROL, `KIND_LINK, `KIND_ELEV, `KIND_SLOT,
			`KIND_GROUP: needs_retx = want_rsp;
			default: needs_retx = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Receive classification
	// RULE1: only flagged packets are control packets
	assign rx_ctl = rx_valid && rx_hdr.ctl_flag;
	// RULE2: reply must match kind of open request
	assign rsp_hit = rx_ctl && rx_hdr.is_reply && req_busy
		&& rx_hdr.kind == req_pkt.hdr.kind;
	assign rx_req = rx_ctl && !rx_hdr.is_reply;
	// RULE24: same kind, sender and content means duplicate
	assign dup = rx_req && have_last && rx_hdr.kind == last_hdr.kind
		&& rx_hdr.local_node_ident_field == last_hdr.local_node_ident_field
		&& rx_payload == last_pl;
	assign third_hit = rx_req && !dup && rsp_busy
		&& rx_hdr.local_node_ident_field == rep_pkt.hdr.local_node_ident_field;

	// RULE5: one engine per side of a transaction
	retx_engine #(.TIMEOUT_CYC(RETRY_TIMEOUT_CYC), .LIMIT(RETRY_LIMIT)) u_req (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_cmd && needs_retx),
		.stop(rsp_hit),
		.resend(req_resend),
		.fail(req_fail_p),
		.busy(req_busy),
		.cnt(req_cnt)
	);
	// RULE14: responder retries its reply until third message
	retx_engine #(.TIMEOUT_CYC(RETRY_TIMEOUT_CYC), .LIMIT(RETRY_LIMIT)) u_rsp (
		.pclk(pclk),
		.presetn(presetn),
		.start(reply_cmd && third_cmd),
		.stop(third_hit),
		.resend(rsp_resend),
		.fail(rsp_fail_p),
		.busy(rsp_busy),
		.cnt(rsp_cnt)
	);

	////////////////////////////////////////////////////////////////////
	// Transaction and transmit next values
	always_comb begin
		next_req_pkt = req_pkt;
		next_rep_pkt = rep_pkt;
		next_pend_req = pend_req;
		next_pend_rep = pend_rep;
		next_have_rep = have_rep;
		next_req_done = req_done;
		next_req_fail = req_fail;
		next_rsp_fail = rsp_fail;
		next_new_msg = new_msg;
		next_last_hdr = last_hdr;
		next_last_pl = last_pl;
		next_have_last = have_last;
		next_link_up = link_up;
		next_tx_valid = tx_valid;
		next_tx_hdr = tx_hdr;
		next_tx_payload = tx_payload;
		// Launch first; later sets win over the clears here
		if (!tx_valid || tx_ready) begin
			next_tx_valid = pend_rep || pend_req;
			if (pend_rep) begin
				next_tx_hdr = rep_pkt.hdr;
				next_tx_payload = rep_pkt.payload;
				next_pend_rep = 1'b0;
			end else if (pend_req) begin
				next_tx_hdr = req_pkt.hdr;
				next_tx_payload = req_pkt.payload;
				next_pend_req = 1'b0;
			end
		end
		// RULE3: payload snapshot follows header kind
		if (start_cmd) begin
			next_req_pkt = '{hdr: out_hdr, payload: tx_pl};
			next_pend_req = 1'b1;
			next_req_done = 1'b0;
			next_req_fail = 1'b0;
		end
		// RULE9: resend the stored request
		if (req_resend) begin
			next_pend_req = 1'b1;
		end
		// RULE7: matching reply completes transaction
		if (rsp_hit) begin
			next_req_done = 1'b1;
			if (rx_hdr.kind == `KIND_ENROL && !rx_payload[`ENR_NEG_BIT]) begin
				next_link_up = 1'b1;
			end
		end
		// RULE10: failure shown in status
		if (req_fail_p) begin
			next_req_fail = 1'b1;
			// RULE11: service node drops to disconnected
			if (!role_base) begin
				next_link_up = 1'b0;
			end
		end
		// RULE13: new request waits for software reply
		if (reply_cmd) begin
			next_rep_pkt = '{hdr: out_hdr, payload: tx_pl};
			next_have_rep = 1'b1;
			next_pend_rep = 1'b1;
			next_rsp_fail = 1'b0;
		end
		if (rsp_resend) begin
			next_pend_rep = 1'b1;
		end
		if (rsp_fail_p) begin
			next_rsp_fail = 1'b1;
		end
		if (ack_cmd) begin
			next_new_msg = 1'b0;
		end
		// RULE12: duplicate only resends the kept reply
		if (dup && have_rep) begin
			next_pend_rep = 1'b1;
		end else if (rx_req && !dup) begin
			next_last_hdr = rx_hdr;
			next_last_pl = rx_payload;
			next_have_last = 1'b1;
			next_new_msg = 1'b1;
		end
		// RULE8: stray replies fall through untouched
	end

	// Transaction registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_pkt <= '0;
			rep_pkt <= '0;
			pend_req <= 1'b0;
			pend_rep <= 1'b0;
			have_rep <= 1'b0;
			req_done <= 1'b0;
			req_fail <= 1'b0;
			rsp_fail <= 1'b0;
			new_msg <= 1'b0;
			last_hdr <= '0;
			last_pl <= '0;
			have_last <= 1'b0;
			link_up <= 1'b0;
			tx_valid <= 1'b0;
			tx_hdr <= '0;
			tx_payload <= '0;
		end else begin
			req_pkt <= next_req_pkt;
			rep_pkt <= next_rep_pkt;
			pend_req <= next_pend_req;
			pend_rep <= next_pend_rep;
			have_rep <= next_have_rep;
			req_done <= next_req_done;
			req_fail <= next_req_fail;
			rsp_fail <= next_rsp_fail;
			new_msg <= next_new_msg;
			last_hdr <= next_last_hdr;
			last_pl <= next_last_pl;
			have_last <= next_have_last;
			link_up <= next_link_up;
			tx_valid <= next_tx_valid;
			tx_hdr <= next_tx_hdr;
			tx_payload <= next_tx_payload;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	ctl_flag_out_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		tx_valid |-> tx_hdr.ctl_flag)
		else $error("control packet sent without control flag");
	late_reply_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		rx_ctl && rx_hdr.is_reply && !req_busy && !start_cmd |=> $stable(req_done))
		else $error("late reply changed transaction state");
	dup_keeps_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		dup && have_rep |=> pend_rep || (tx_valid && tx_hdr.is_reply))
		else $error("duplicate request not answered by reply");
	new_req_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		rx_req && !dup |=> new_msg && last_hdr == $past(rx_hdr))
		else $error("new request not captured");
	ktime_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
		tx_valid && tx_hdr.kind == `KIND_ENROL && !(tx_hdr.is_reply && !tx_hdr.uplink)
		|-> tx_payload[306:304] == 3'b000)
		else $error("keepalive time set outside enrolment response");
	disconnect_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		req_fail_p && !role_base |=> !link_up && req_fail)
		else $error("service node stayed connected after failure");
endmodule

// ==== dv/peer_node.sv ====
// Peer node model that takes the control packets sent by the block
`timescale 1ns/1ps
module peer_node (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tx_valid,
	input wire mcr_pkg::pkt_hdr_t tx_hdr,
	input wire logic [319:0] tx_payload,
	output logic tx_ready,
	output logic [7:0] n_rx,
	output mcr_pkg::pkt_hdr_t last_hdr,
	output logic [63:0] last_top
);
	import mcr_pkg::*;
	////////////////////////////////////////////////////////////
	// Random stalls, so resends meet back-pressure like a busy peer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
			n_rx <= 8'h00;
			last_hdr <= '0;
			last_top <= 64'h0;
		end else begin
			tx_ready <= ($urandom % 3) != 0;
			if (tx_valid && tx_ready) begin
				// only flagged packets count as control
				if (tx_hdr.ctl_flag)
					n_rx <= n_rx + 8'h01;
				last_hdr <= tx_hdr;
				last_top <= tx_payload[319:256];
			end
		end
	end
endmodule

// ==== dv/mac_control_retransmit_tb.sv ====
// Self-checking bench for the control framer
`timescale 1ns/1ps
`include "mcr_consts.svh"
module mac_control_retransmit_tb;
	import mcr_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic rx_valid = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, tx_ready, tx_valid, link_up;
	pkt_hdr_t rx_hdr = '0;
	pkt_hdr_t tx_hdr, last_hdr, h, hh;
	logic [319:0] rx_payload = '0;
	logic [319:0] tx_payload, p;
	logic [7:0] n_rx, n0;
	logic [63:0] last_top;
	logic [15:0] cap;
	logic [47:0] hw;
	int fails = 0;
	int n_tests = 0;
	// Free-running 125 MHz clock
	always #4 pclk = ~pclk;
	// Short timeout keeps retry runs brief
	mac_control_retransmit #(.RETRY_TIMEOUT_CYC(20), .RETRY_LIMIT(3)) mac_control_retransmit_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_hdr(rx_hdr), .rx_payload(rx_payload),
		.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_hdr(tx_hdr),
		.tx_payload(tx_payload), .link_up(link_up));
	peer_node peer_node_i (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
		.tx_hdr(tx_hdr), .tx_payload(tx_payload), .tx_ready(tx_ready), .n_rx(n_rx),
		.last_hdr(last_hdr), .last_top(last_top));
	////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One APB transfer; data taken in the cycle pready stands
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		// Wait ran out: counts as a mismatch
		if (pready !== 1'b1)
			fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One received packet pulse
	task automatic rx(input pkt_hdr_t a, input logic [319:0] b);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_hdr <= a;
		rx_payload <= b;
		@(posedge pclk);
		rx_valid <= 1'b0;
	endtask
	// Poll a status bit, bounded
	task automatic poll(input int b);
		int k;
		k = 0;
		do begin
			apb(1'b0, `STAT_OFS, 32'h0);
			k++;
		end while (rd[b] !== 1'b1 && k < 40);
		// Poll limit ran out: counts as a mismatch
		if (rd[b] !== 1'b1)
			fails++;
	endtask
	// Request flags: reserved and keepalive time zeroed
	function automatic logic [15:0] enc(input logic [15:0] c);
		return {c[15:12], 2'b00, c[9:3], 3'b000};
	endfunction
	task automatic conclude();
		$display("n_tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		conclude();
	end
	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(64));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk(tx_valid, 0);
		chk(link_up, 0);
		apb(1'b0, 8'h30, 32'h0);
		chk(err, 1);
		hw = 48'({$urandom, $urandom});
		cap = 16'($urandom);
		apb(1'b1, `TXHWLO_OFS, hw[31:0]);
		apb(1'b1, `TXHWHI_OFS, {16'h0, hw[47:32]});
		apb(1'b1, `TXCAP_OFS, {8'h00, 8'hff, cap});
		h = '0;
		h.uplink = 1'b1;
		h.kind = `KIND_ENROL;
		h.local_node_ident_field = 14'($urandom);
		apb(1'b1, `TXHDR_OFS, {3'b000, h});
		apb(1'b0, `TXHDR_OFS, 32'h0);
		chk(rd[28:0], h);
		n0 = n_rx;
		apb(1'b1, `CTRL_OFS, 32'h21);
		repeat (12) @(posedge pclk);
		chk(n_rx - n0, 1);
		chk(last_hdr.ctl_flag, 1);
		chk(last_hdr.kind, `KIND_ENROL);
		chk(last_top, {enc(cap), hw});
		apb(1'b0, `STAT_OFS, 32'h0);
		chk({rd[11:8], rd[1]}, 5'h01);
		hh = h;
		hh.ctl_flag = 1'b1;
		hh.is_reply = 1'b1;
		hh.uplink = 1'b0;
		rx(hh, 320'h0);
		apb(1'b0, `STAT_OFS, 32'h0);
		chk(rd[3:1], 3'b010);
		chk(link_up, 1);
		rx(hh, 320'h0);
		apb(1'b0, `STAT_OFS, 32'h0);
		chk(rd[3:1], 3'b010);
		n0 = n_rx;
		apb(1'b1, `CTRL_OFS, 32'h21);
		poll(3);
		chk(rd[11:8], 3);
		chk(rd[7], 0);
		repeat (10) @(posedge pclk);
		chk(n_rx - n0, 3);
		h.kind = `KIND_KALIVE;
		apb(1'b1, `TXHDR_OFS, {3'b000, h});
		apb(1'b1, `CTRL_OFS, 32'h21);
		apb(1'b0, `STAT_OFS, 32'h0);
		chk(rd[1], 0);
		hh.is_reply = 1'b0;
		hh.kind = `KIND_LINK;
		for (int i = 0; i < 10; i++)
			p[i*32 +: 32] = $urandom;
		rx(hh, p);
		apb(1'b0, `STAT_OFS, 32'h0);
		chk(rd[6], 1);
		apb(1'b0, `RXHDR_OFS, 32'h0);
		chk(rd[28:0], hh);
		apb(1'b0, `RXHWLO_OFS, 32'h0);
		chk(rd, p[287:256]);
		apb(1'b1, `CTRL_OFS, 32'h08);
		rx(hh, p);
		apb(1'b0, `STAT_OFS, 32'h0);
		chk(rd[6], 0);
		// Base role, downlink enrolment reply, one hop lacks aggregation
		h.kind = `KIND_ENROL;
		h.uplink = 1'b0;
		apb(1'b1, `TXHDR_OFS, {3'b000, h});
		apb(1'b1, `TXCAP_OFS, {8'h00, 8'hfe, 16'hffff});
		apb(1'b1, `CTRL_OFS, 32'h10);
		n0 = n_rx;
		// Reply that waits for a third message
		apb(1'b1, `CTRL_OFS, 32'h16);
		repeat (8) @(posedge pclk);
		// Reserved cleared, aggregation 0, keepalive time kept
		chk(last_top[63:48], 16'hf2ff);
		chk(last_top[50:48], 3'h7);
		// Duplicate request: kept reply goes out again
		rx(hh, p);
		repeat (8) @(posedge pclk);
		chk(n_rx - n0, 2);
		// One responder timeout resends the reply
		repeat (12) @(posedge pclk);
		chk(n_rx - n0, 3);
		// Third message from the same node ends the responder engine
		rx(hh, ~p);
		apb(1'b0, `STAT_OFS, 32'h0);
		chk({rd[15:12], rd[5:4]}, 6'h04);
		conclude();
	end
endmodule
